// file: adram_ctrl.sv
// host controller driving an asynchronous x16 paged dram through its pins
//
// Overview of operation
// - column address on lines 0-7 at column fall
// - refresh all 1024 rows every 16 or 128 ms
// - row-only refresh: row low, column high
// - column-first refresh ignores write enables, outputs open
// - column fall with write enables high reads
// - write enable low before column fall: early write
// - write enable after column fall: delayed write
// - read-modify-write: read first, then write same location
// - page mode early writes within one open row
// - page mode delayed writes within one open row
// - page mode read-modify-write within one open row
// - all strobes and enables are active low
// - 16-bit shared data pins in two byte lanes
`timescale 1ns/1ps
`default_nettype none
`include "adram_defs.svh"

module adram_ctrl
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_req_valid,
    input wire adram_pkg::adram_req_t i_req,
    output logic o_req_ready,
    output logic [`ADRAM_DATA_BITS-1:0] o_rdata,
    output logic o_rdata_valid,
    input wire logic i_low_power_variant,
    input wire logic i_row_only_refresh,
    input wire logic i_self_refresh_req,
    output logic o_self_refresh_active,
    output logic o_ras_n,
    output logic o_cas_n,
    output logic o_upper_byte_write_en_n,
    output logic o_lower_byte_write_en_n,
    output logic o_oe_n,
    output logic [`ADRAM_ROW_BITS-1:0] o_addr,
    output logic [`ADRAM_DATA_BITS-1:0] o_dq,
    output logic o_dq_oe,
    input wire logic [`ADRAM_DATA_BITS-1:0] i_dq
);

    localparam int CW = `ADRAM_CNT_BITS;

    typedef enum logic [3:0] {
        S_IDLE,
        S_ROW,
        S_RCD,
        S_CASL,
        S_HOLD,
        S_TURN,
        S_WEL,
        S_WEH,
        S_CUP,
        S_PRE,
        S_CFREF,
        S_ROR,
        S_REF,
        S_SELF
    } adram_state_t;

    adram_state_t state_reg;
    adram_pkg::adram_req_t req_reg;
    logic [CW-1:0] wait_reg;
    logic [CW-1:0] page_reg;
    logic [CW-1:0] ref_cnt_reg;
    logic ref_due_reg;
    logic sr_mode_reg;
    logic ror_mode_reg;
    logic [`ADRAM_ROW_BITS-1:0] ref_row_reg;

    function automatic logic [`ADRAM_ROW_BITS-1:0] row_of(
        input logic [`ADRAM_ADDR_BITS-1:0] a);
        row_of = a[`ADRAM_ROW_MSB:`ADRAM_ROW_LSB];
    endfunction : row_of

    function automatic logic is_read_phase(input adram_pkg::adram_op_t op);
        is_read_phase = (op == adram_pkg::OP_READ) ||
                        (op == adram_pkg::OP_READ_MODIFY_WRITE);
    endfunction : is_read_phase

    logic busy_ref;
    logic start_ref;
    logic accept_new;
    logic page_open_ok;
    logic accept_page;
    logic wait_done;

    assign busy_ref = ref_due_reg || i_self_refresh_req;
    assign start_ref = (state_reg == S_IDLE) && busy_ref;
    // keep the row open no longer than the longest row-low time allows
    assign page_open_ok = page_reg <
        CW'(`ADRAM_RASC_CYC - `ADRAM_PAGE_MARGIN);
    assign accept_new = (state_reg == S_IDLE) && !busy_ref && i_req_valid;
    assign accept_page = (state_reg == S_CUP) && !busy_ref && i_req_valid &&
                         page_open_ok &&
                         (row_of(i_req.addr) == row_of(req_reg.addr));
    assign o_req_ready = !busy_ref &&
        ((state_reg == S_IDLE) ||
         ((state_reg == S_CUP) && page_open_ok &&
          (row_of(i_req.addr) == row_of(req_reg.addr))));
    assign wait_done = (wait_reg == '0);
    assign o_self_refresh_active = (state_reg == S_SELF);

    // sequencing
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_reg <= S_IDLE;
            wait_reg <= '0;
        end
        else
        begin
            case (state_reg)
                S_IDLE:
                begin
                    if (start_ref)
                        state_reg <= (i_row_only_refresh &&
                                      !i_self_refresh_req) ? S_ROR : S_CFREF;
                    else if (accept_new)
                        state_reg <= S_ROW;
                end
                S_ROW: state_reg <= S_RCD;
                S_RCD: state_reg <= S_CASL;
                S_CASL: state_reg <= S_HOLD;
                S_HOLD:
                begin
                    case (req_reg.op)
                        adram_pkg::OP_READ_MODIFY_WRITE: state_reg <= S_TURN;
                        adram_pkg::OP_WRITE_DELAYED: state_reg <= S_WEL;
                        default: state_reg <= S_CUP;
                    endcase
                end
                S_TURN: state_reg <= S_WEL;
                S_WEL: state_reg <= S_WEH;
                S_WEH: state_reg <= S_CUP;
                S_CUP:
                begin
                    if (accept_page)
                        state_reg <= S_RCD;
                    else
                    begin
                        state_reg <= S_PRE;
                        wait_reg <= CW'(`ADRAM_RP_CYC - 1);
                    end
                end
                S_CFREF, S_ROR:
                begin
                    state_reg <= S_REF;
                    wait_reg <= CW'(`ADRAM_RAS_CYC - 1);
                end
                S_REF:
                begin
                    if (!wait_done)
                        wait_reg <= wait_reg - CW'(1);
                    else if (sr_mode_reg)
                    begin
                        state_reg <= S_SELF;
                        wait_reg <= CW'(`ADRAM_RASS_CYC - `ADRAM_RAS_CYC);
                    end
                    else
                    begin
                        state_reg <= S_PRE;
                        wait_reg <= CW'(`ADRAM_RP_CYC - 1);
                    end
                end
                S_SELF:
                begin
                    // the minimum self refresh time is served before exit
                    if (!wait_done)
                        wait_reg <= wait_reg - CW'(1);
                    else if (!i_self_refresh_req)
                    begin
                        state_reg <= S_PRE;
                        wait_reg <= CW'(`ADRAM_RPS_CYC - 1);
                    end
                end
                S_PRE:
                begin
                    if (!wait_done)
                        wait_reg <= wait_reg - CW'(1);
                    else
                        state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // strobes, enables and address pins, all active low strobes
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_ras_n <= 1'b1;
            o_cas_n <= 1'b1;
            o_upper_byte_write_en_n <= 1'b1;
            o_lower_byte_write_en_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_addr <= '0;
        end
        else
        begin
            case (state_reg)
                S_IDLE:
                begin
                    if (start_ref && i_row_only_refresh && !i_self_refresh_req)
                        o_addr <= ref_row_reg;
                    else if (start_ref)
                        o_cas_n <= 1'b0;
                    else if (accept_new)
                        o_addr <= row_of(i_req.addr);
                end
                S_ROW: o_ras_n <= 1'b0;
                S_RCD:
                begin
                    o_addr <= {{(`ADRAM_ROW_BITS-`ADRAM_COL_BITS){1'b0}},
                               req_reg.addr[`ADRAM_COL_MSB:0]};
                    if (req_reg.op == adram_pkg::OP_WRITE_EARLY)
                    begin
                        // both lanes fall on one edge so the combined mode
                        // sees a single start and end
                        o_upper_byte_write_en_n <= !req_reg.byte_en[1];
                        o_lower_byte_write_en_n <= !req_reg.byte_en[0];
                    end
                    if (is_read_phase(req_reg.op))
                        o_oe_n <= 1'b0;
                end
                S_CASL: o_cas_n <= 1'b0;
                S_HOLD:
                begin
                    if (req_reg.op == adram_pkg::OP_READ_MODIFY_WRITE)
                        o_oe_n <= 1'b1; // release before driving data
                end
                S_WEL:
                begin
                    o_upper_byte_write_en_n <= !req_reg.byte_en[1];
                    o_lower_byte_write_en_n <= !req_reg.byte_en[0];
                end
                S_WEH:
                begin
                    o_cas_n <= 1'b1;
                    o_upper_byte_write_en_n <= 1'b1;
                    o_lower_byte_write_en_n <= 1'b1;
                end
                S_CUP:
                begin
                    o_oe_n <= 1'b1;
                    o_cas_n <= 1'b1;
                    o_upper_byte_write_en_n <= 1'b1;
                    o_lower_byte_write_en_n <= 1'b1;
                    if (!accept_page)
                        o_ras_n <= 1'b1;
                end
                S_CFREF, S_ROR: o_ras_n <= 1'b0;
                S_REF:
                begin
                    if (wait_done && !sr_mode_reg)
                    begin
                        o_ras_n <= 1'b1;
                        o_cas_n <= 1'b1;
                    end
                end
                S_SELF:
                begin
                    if (wait_done && !i_self_refresh_req)
                    begin
                        o_ras_n <= 1'b1;
                        o_cas_n <= 1'b1;
                    end
                end
                default:
                begin
                    o_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // request capture and data path on the shared pins
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            req_reg <= '0;
            o_dq <= '0;
            o_dq_oe <= 1'b0;
            o_rdata <= '0;
            o_rdata_valid <= 1'b0;
        end
        else
        begin
            o_rdata_valid <= 1'b0;
            if (accept_new || accept_page)
                req_reg <= i_req;
            if ((state_reg == S_RCD) &&
                (req_reg.op == adram_pkg::OP_WRITE_EARLY))
            begin
                o_dq <= req_reg.wdata;
                o_dq_oe <= 1'b1;
            end
            // data is only driven once the device output enable is high
            if ((state_reg == S_HOLD &&
                 req_reg.op == adram_pkg::OP_WRITE_DELAYED) ||
                state_reg == S_TURN)
            begin
                o_dq <= req_reg.wdata;
                o_dq_oe <= 1'b1;
            end
            if (state_reg == S_HOLD && is_read_phase(req_reg.op))
            begin
                o_rdata <= i_dq;
                o_rdata_valid <= 1'b1;
            end
            if (state_reg == S_CUP || state_reg == S_WEH)
                o_dq_oe <= 1'b0;
        end
    end

    // refresh pacing: one row per interval, set wins over clear
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ref_cnt_reg <= '0;
            ref_due_reg <= 1'b0;
            ref_row_reg <= '0;
            sr_mode_reg <= 1'b0;
            ror_mode_reg <= 1'b0;
        end
        else
        begin
            if (ref_cnt_reg == '0)
            begin
                ref_cnt_reg <= i_low_power_variant ?
                    CW'(`ADRAM_REF_LP_CYC - 1) :
                    CW'(`ADRAM_REF_CYC - 1);
                ref_due_reg <= 1'b1;
            end
            else
            begin
                ref_cnt_reg <= ref_cnt_reg - CW'(1);
                if (start_ref)
                    ref_due_reg <= 1'b0;
            end
            if (start_ref)
            begin
                sr_mode_reg <= i_self_refresh_req;
                ror_mode_reg <= i_row_only_refresh && !i_self_refresh_req;
            end
            if (state_reg == S_REF && wait_done && ror_mode_reg)
                ref_row_reg <= ref_row_reg + `ADRAM_ROW_BITS'(1);
        end
    end

    // time the row has been open in page mode
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            page_reg <= '0;
        else if (accept_new)
            page_reg <= '0;
        else if (page_reg != '1)
            page_reg <= page_reg + CW'(1);
    end

endmodule : adram_ctrl

`default_nettype wire

// file: adram_ctrl_asserts.sv
// pin-level checks on the paged dram controller
`timescale 1ns/1ps
`default_nettype none
module adram_ctrl_asserts
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_low_power_variant,
    input wire logic i_row_only_refresh,
    input wire logic o_self_refresh_active,
    input wire logic o_ras_n,
    input wire logic o_cas_n,
    input wire logic o_upper_byte_write_en_n,
    input wire logic o_lower_byte_write_en_n,
    input wire logic o_oe_n,
    input wire logic [9:0] o_addr,
    input wire logic o_dq_oe,
    input wire logic [15:0] o_rdata,
    input wire logic o_rdata_valid,
    input wire logic [15:0] i_dq
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    logic we_idle;
    logic [11:0] gap_cnt;
    assign we_idle = o_upper_byte_write_en_n & o_lower_byte_write_en_n;
    // gap tracked only in the 16 ms column-first mode
    always_ff @(posedge i_clk or negedge i_reset_n)
        if (!i_reset_n)
            gap_cnt <= 12'h0;
        else if ((!o_cas_n && $fell(o_ras_n)) || i_row_only_refresh
            || i_low_power_variant || o_self_refresh_active)
            gap_cnt <= 12'h0;
        else
            gap_cnt <= gap_cnt + 12'h1;
    sequence s_col_fall;
        $fell(o_cas_n) && !o_ras_n;
    endsequence
    sequence s_col_first_entry;
        o_ras_n && !o_cas_n ##1 !o_ras_n;
    endsequence
    a_row_addr_held:
        assert property ($fell(o_ras_n) && o_cas_n && !i_row_only_refresh
            |-> $stable(o_addr)) else $error("row address moved");
    a_col_addr_ok:
        assert property (s_col_fall |-> $stable(o_addr) && !(|o_addr[9:8]))
        else $error("bad column address");
    a_col_first_quiet:
        assert property (s_col_first_entry
            |-> we_idle && !o_dq_oe ##1 !o_ras_n)
        else $error("bad column-first refresh");
    a_read_answer:
        assert property (s_col_fall ##0 (we_idle && !o_oe_n)
            |=> o_rdata_valid && o_rdata == $past(i_dq))
        else $error("read data not returned");
    a_early_write:
        assert property (s_col_fall ##0 !we_idle
            |-> o_dq_oe && o_oe_n ##1 !we_idle) else $error("bad early write");
    a_late_write:
        assert property (!o_ras_n && !o_cas_n && $fell(we_idle)
            |-> o_dq_oe && $past(o_dq_oe) && o_oe_n)
        else $error("bad delayed write");
    a_no_contention:
        assert property (!o_oe_n |-> !o_dq_oe) else $error("data pin fight");
    a_write_in_row:
        assert property (!we_idle |-> !o_ras_n && o_dq_oe)
        else $error("write outside row");
    a_refresh_gap:
        assert property (gap_cnt <= 12'd410) else $error("refresh late");
endmodule : adram_ctrl_asserts
bind adram_ctrl adram_ctrl_asserts u_chk (.i_clk, .i_reset_n,
    .i_low_power_variant, .i_row_only_refresh, .o_self_refresh_active,
    .o_ras_n, .o_cas_n, .o_upper_byte_write_en_n, .o_lower_byte_write_en_n,
    .o_oe_n, .o_addr, .o_dq_oe, .o_rdata, .o_rdata_valid, .i_dq);
`default_nettype wire

// file: adram_defs.svh
// timing counts and address layout for the paged dram controller
`ifndef ADRAM_DEFS_SVH
`define ADRAM_DEFS_SVH

`define ADRAM_CLK_NS 40
// least time in ns rounded up to whole clock cycles, never below one
`define ADRAM_CYC_MIN(ns) \
    ((((ns) + `ADRAM_CLK_NS - 1) / `ADRAM_CLK_NS) < 1 ? 1 : \
     (((ns) + `ADRAM_CLK_NS - 1) / `ADRAM_CLK_NS))

`define ADRAM_ROW_MSB 17
`define ADRAM_ROW_LSB 8
`define ADRAM_COL_MSB 7
`define ADRAM_ROW_BITS 10
`define ADRAM_COL_BITS 8
`define ADRAM_ADDR_BITS 18
`define ADRAM_DATA_BITS 16

`define ADRAM_T_RP_NS 50
`define ADRAM_T_RAS_NS 70
`define ADRAM_T_RPS_NS 130
`define ADRAM_T_RASS_US 100
`define ADRAM_T_RASC_US 100
`define ADRAM_REF_ROWS 1024
`define ADRAM_REF_PERIOD_MS 16
`define ADRAM_REF_PERIOD_LP_MS 128

`define ADRAM_RP_CYC `ADRAM_CYC_MIN(`ADRAM_T_RP_NS)
`define ADRAM_RAS_CYC `ADRAM_CYC_MIN(`ADRAM_T_RAS_NS)
`define ADRAM_RPS_CYC `ADRAM_CYC_MIN(`ADRAM_T_RPS_NS)
`define ADRAM_RASS_CYC `ADRAM_CYC_MIN(`ADRAM_T_RASS_US * 1000)
// longest times round down
`define ADRAM_RASC_CYC ((`ADRAM_T_RASC_US * 1000) / `ADRAM_CLK_NS)
`define ADRAM_PAGE_MARGIN 8
`define ADRAM_REF_CYC \
    ((`ADRAM_REF_PERIOD_MS * 1000000 / `ADRAM_REF_ROWS) / `ADRAM_CLK_NS)
`define ADRAM_REF_LP_CYC \
    ((`ADRAM_REF_PERIOD_LP_MS * 1000000 / `ADRAM_REF_ROWS) / `ADRAM_CLK_NS)
`define ADRAM_CNT_BITS 12

`endif

// file: adram_mem_model.sv
// behavioural x16 paged dram standing on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module adram_mem_model
#(
    parameter int ACC_NS = 5
)
(
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_upper_byte_write_en_n,
    input wire logic i_lower_byte_write_en_n,
    input wire logic i_oe_n,
    input wire logic [9:0] i_addr,
    input wire logic [15:0] i_host_dq,
    input wire logic i_host_dq_oe,
    output logic [15:0] o_bus,
    output logic [15:0] o_col_first_cnt,
    output logic [9:0] o_ro_row
);
    logic [15:0] mem [int];
    logic [15:0] dout = 16'h0;
    logic [15:0] flt = 16'h5a3c;
    logic [1:0] drv;
    // starts at the idle report so the power-up strobe edge adds no row
    logic [9:0] row = 10'h3ff;
    logic col_first = 1'b0;
    logic col_seen = 1'b0;
    logic rd;
    int idx;
    initial
    begin
        o_col_first_cnt = 16'h0;
        o_ro_row = 10'h3ff;
    end
    // released pins wander so a stale value never passes for data
    always #40 flt = {flt[14:0], ~flt[15]};
    always @(negedge i_ras_n)
    begin
        row = i_addr;
        col_seen = 1'b0;
        col_first = !i_cas_n;
        if (col_first)
            o_col_first_cnt++;
    end
    always @(posedge i_ras_n)
        if (!col_first && !col_seen)
            o_ro_row = row;
    task automatic wr();
        if (!i_lower_byte_write_en_n)
            mem[idx][7:0] = o_bus[7:0];
        if (!i_upper_byte_write_en_n)
            mem[idx][15:8] = o_bus[15:8];
    endtask : wr
    always @(negedge i_cas_n)
        if (!i_ras_n && !col_first)
        begin
            idx = {row, i_addr[7:0]};
            col_seen = 1'b1;
            dout = mem.exists(idx) ? mem[idx] : 16'h0;
            wr();
        end
    always @(negedge (i_upper_byte_write_en_n & i_lower_byte_write_en_n))
        if (!i_ras_n && !i_cas_n && col_seen)
            wr();
    assign rd = !i_ras_n && !i_cas_n && !i_oe_n && col_seen;
    assign #(ACC_NS) drv = {rd && i_upper_byte_write_en_n,
        rd && i_lower_byte_write_en_n};
    assign o_bus = i_host_dq_oe ? i_host_dq :
        {drv[1] ? dout[15:8] : flt[15:8], drv[0] ? dout[7:0] : flt[7:0]};
endmodule : adram_mem_model
`default_nettype wire

// file: adram_pkg.sv
// types shared by the paged dram controller
`default_nettype none
`include "adram_defs.svh"

package adram_pkg;

    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE_EARLY,
        OP_WRITE_DELAYED,
        OP_READ_MODIFY_WRITE
    } adram_op_t;

    typedef struct packed {
        adram_op_t op;
        logic [1:0] byte_en;
        logic [`ADRAM_ADDR_BITS-1:0] addr;
        logic [`ADRAM_DATA_BITS-1:0] wdata;
    } adram_req_t;

endpackage : adram_pkg

`default_nettype wire

// file: tb_async_dram_x16_page_interface.sv
// self-checking bench: controller against the behavioural dram
`timescale 1ns/1ps
`default_nettype none
module tb_async_dram_x16_page_interface;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_req_valid = 1'b0;
    adram_pkg::adram_req_t i_req = '0;
    logic i_low_power_variant = 1'b0;
    logic i_row_only_refresh = 1'b0;
    logic i_self_refresh_req = 1'b0;
    logic o_req_ready, o_rdata_valid, o_self_refresh_active, o_dq_oe;
    logic o_ras_n, o_cas_n, o_oe_n;
    logic o_upper_byte_write_en_n, o_lower_byte_write_en_n;
    logic [9:0] o_addr, ro_row, r0;
    logic [15:0] o_rdata, o_dq, i_dq, col_first_cnt, n, c0;
    int err_total = 0;
    int tests_run = 0;
    always #20 i_clk = ~i_clk;
    adram_ctrl dut (.i_clk, .i_reset_n, .i_req_valid, .i_req, .o_req_ready,
        .o_rdata, .o_rdata_valid, .i_low_power_variant, .i_row_only_refresh,
        .i_self_refresh_req, .o_self_refresh_active, .o_ras_n, .o_cas_n,
        .o_upper_byte_write_en_n, .o_lower_byte_write_en_n, .o_oe_n, .o_addr,
        .o_dq, .o_dq_oe, .i_dq);
    adram_mem_model #(.ACC_NS(30)) u_mem (.i_ras_n(o_ras_n),
        .i_cas_n(o_cas_n),
        .i_upper_byte_write_en_n(o_upper_byte_write_en_n),
        .i_lower_byte_write_en_n(o_lower_byte_write_en_n),
        .i_oe_n(o_oe_n), .i_addr(o_addr),
        .i_host_dq(o_dq), .i_host_dq_oe(o_dq_oe), .o_bus(i_dq),
        .o_col_first_cnt(col_first_cnt), .o_ro_row(ro_row));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // one edge passes before each request so valid never toggles twice
    task automatic xfer(input logic [1:0] op, input logic [1:0] be,
        input logic [17:0] a, input logic [15:0] d, input logic [15:0] exp);
        int k;
        @(posedge i_clk);
        #1 i_req = {op, be, a, d};
        i_req_valid = 1'b1;
        k = 0;
        do
        begin
            @(negedge i_clk);
            k++;
        end
        while (o_req_ready !== 1'b1 && k < 3000);
        // a request never taken counts as a mismatch
        check({15'h0, o_req_ready}, 16'h1);
        @(posedge i_clk);
        #1 i_req_valid = 1'b0;
        k = 0;
        while (op[0] == op[1] && o_rdata_valid !== 1'b1 && k < 20)
        begin
            @(negedge i_clk);
            k++;
        end
        if (op[0] == op[1])
            check(o_rdata_valid ? o_rdata : ~exp, exp);
    endtask : xfer
    task automatic t_page();
        xfer(2'd1, 2'b11, 18'h3a5fe, 16'hbeef, 16'h0);
        xfer(2'd1, 2'b11, 18'h3a5ff, 16'h1234, 16'h0);
        xfer(2'd0, 2'b11, 18'h3a5fe, 16'h0, 16'hbeef);
        xfer(2'd0, 2'b11, 18'h3a5ff, 16'h0, 16'h1234);
    endtask : t_page
    task automatic t_lanes();
        xfer(2'd1, 2'b11, 18'h00c03, 16'h1111, 16'h0);
        xfer(2'd1, 2'b01, 18'h00c03, 16'haabb, 16'h0);
        xfer(2'd2, 2'b10, 18'h00c03, 16'hccdd, 16'h0);
        xfer(2'd1, 2'b00, 18'h00c03, 16'hffff, 16'h0);
        xfer(2'd2, 2'b11, 18'h00c04, 16'h5678, 16'h0);
        xfer(2'd0, 2'b11, 18'h00c03, 16'h0, 16'hccbb);
        xfer(2'd0, 2'b11, 18'h00c04, 16'h0, 16'h5678);
    endtask : t_lanes
    task automatic t_rmw();
        xfer(2'd3, 2'b11, 18'h00c03, 16'h9999, 16'hccbb);
        xfer(2'd3, 2'b01, 18'h00c03, 16'h7777, 16'h9999);
        xfer(2'd0, 2'b11, 18'h00c03, 16'h0, 16'h9977);
    endtask : t_rmw
    task automatic t_refresh();
        c0 = col_first_cnt;
        repeat (4000) @(posedge i_clk);
        #1 n = col_first_cnt - c0;
        check({15'h0, n >= 16'd10 && n <= 16'd11}, 16'h1);
        i_row_only_refresh = 1'b1;
        for (int j = 0; j < 2; j++)
        begin
            r0 = ro_row;
            repeat (500) if (ro_row == r0) @(negedge i_clk);
        end
        check({6'h0, ro_row}, {6'h0, r0 + 10'd1});
        xfer(2'd0, 2'b11, 18'h3a5fe, 16'h0, 16'hbeef);
        @(posedge i_clk);
        #1 i_row_only_refresh = 1'b0;
    endtask : t_refresh
    task automatic t_self();
        @(posedge i_clk);
        #1 i_self_refresh_req = 1'b1;
        repeat (2700) @(posedge i_clk);
        #1 check({15'h0, o_self_refresh_active}, 16'h1);
        i_self_refresh_req = 1'b0;
        repeat (20) @(posedge i_clk);
        #1 check({15'h0, o_self_refresh_active}, 16'h0);
        xfer(2'd0, 2'b11, 18'h00c03, 16'h0, 16'h9977);
    endtask : t_self
    task automatic t_lowpow();
        @(posedge i_clk);
        #1 i_low_power_variant = 1'b1;
        repeat (400) @(posedge i_clk);
        #1 c0 = col_first_cnt;
        repeat (3200) @(posedge i_clk);
        #1 check(col_first_cnt - c0, 16'h1);
    endtask : t_lowpow
    initial
    begin
        #800000;
        err_total++;
        final_report();
    end
    initial
    begin
        repeat (8) @(posedge i_clk);
        #1 i_reset_n = 1'b1;
        t_page();
        t_lanes();
        t_rmw();
        t_refresh();
        t_self();
        t_lowpow();
        final_report();
    end
endmodule : tb_async_dram_x16_page_interface
`default_nettype wire
